// *** verilog/spi_mem_defs.svh ***
// constants of the serial nonvolatile memory command slave: op-codes, status layout
// assumes it is included by the design file, never compiled on its own
// How it works
// - write-enable op-code sets the write-enable latch
// - write-disable op-code clears the latch; writes then do nothing
// - status read shifts status byte out, repeating while clocks continue
// - status write takes 8 bits, ignoring latch bit 1 and bit 0
// - array read: 16-bit address, top bit ignored, byte out on falls
// - further read bytes come from incremented addresses, wrapping to zero
// - array write: 16-bit address, byte committed after its 8th bit
// - further write bytes go to incremented addresses, wrapping to zero
// - fast read: address, 8 dummy bits, then data on falling edges
// - fast read continues at next addresses until chip select rises
// - identity read sends fixed 32-bit identifier, most significant byte first
// - after 32 bits serial output holds the last identifier bit
// - chip select rising mid op-code discards it; no command runs
// - block-guard bits select which upper part of the array refuses writes
// - latch clear refuses all; status refused when lock set and pin low
// - hold suspends command, ignores clock and input, floats output
// - chip select rising in hold aborts; latch keeps its value unless a write was recognised
// - input sampled on rising clock edges, output changes on falling
// - latch cleared at reset, write-disable, and end of recognised writes
// - status byte: lock, spare bits, guard bits, latch, constant zero
// - chip select high: deselected, output floats; commands start on fall
`ifndef SPI_MEM_DEFS_SVH
`define SPI_MEM_DEFS_SVH

// ------------------------------------------------------------------
// op-codes
// ------------------------------------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02
`define OP_IDENTITY_READ 8'h9f
`define OP_FAST_READ 8'h0b

// ------------------------------------------------------------------
// counts and reset values
// ------------------------------------------------------------------
`define LAST_BYTE_BIT 6'h07
`define LAST_ADDR_BIT 6'h0f
`define ID_BIT_COUNT 6'h20
`define STATUS_NV_RESET 6'h00

`endif

// *** verilog/spi_mem_pkg.sv ***
// types of the serial nonvolatile memory command slave
// assumes nothing of its surroundings
package spi_mem_pkg;

  // ------------------------------------------------------------------
  // command phases
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OPCODE = 4'h0,
    ST_ADDR = 4'h1,
    ST_DUMMY = 4'h2,
    ST_RDATA = 4'h3,
    ST_WDATA = 4'h4,
    ST_STREAD = 4'h5,
    ST_STWRITE = 4'h6,
    ST_IDOUT = 4'h7,
    ST_IGNORE = 4'h8
  } cmd_state_type;

  // kind of array access that follows the address
  typedef enum logic [1:0] {
    ACC_READ = 2'h0,
    ACC_FAST = 2'h1,
    ACC_WRITE = 2'h2
  } access_type;

endpackage

// *** verilog/spi_mem_slave.sv ***
// serial memory command slave with a small write buffer in front of the array
// assumes mclk well above the serial clock (8x or more); all pins asynchronous to mclk
`timescale 1ns/1ps
`include "spi_mem_defs.svh"

// ------------------------------------------------------------------
// write buffer
// ------------------------------------------------------------------
module spi_mem_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [CW-1:0] count_r;
  logic doPush;
  logic doPop;

  // honest full and empty from the occupancy count
  assign inReady = count_r != CW'(DEPTH);
  assign outValid = count_r != '0;
  assign outData = store_r[rdPtr_r];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // pointers wrap naturally; depth must be a power of two
  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) wrPtr_r <= wrPtr_r + 1'b1;
      if (doPop) rdPtr_r <= rdPtr_r + 1'b1;
      if (doPush && !doPop) count_r <= count_r + 1'b1;
      else if (doPop && !doPush) count_r <= count_r - 1'b1;
    end
  end

  // storage carries no reset, only data
  always_ff @(posedge mclk) begin
    if (doPush) store_r[wrPtr_r] <= inData;
  end
endmodule

// ------------------------------------------------------------------
// command slave
// ------------------------------------------------------------------
module spi_mem_slave #(
  parameter int ADDR_W = 15,
  parameter int FIFO_DEPTH = 8,
  parameter logic [31:0] ID_WORD = 32'h5a01c3e4 // arbitrary identifier value
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic holdN,
  input wire logic guardPinN,
  output logic so,
  output logic soEn,
  output logic bufReady
);
  localparam int WW = ADDR_W + 8;

  spi_mem_pkg::cmd_state_type state_r;
  spi_mem_pkg::access_type access_r;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic sckPrev_r;
  logic csLowPrev_r;
  logic [5:0] bitCnt_r;
  logic [7:0] sh_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] mem_r [2**ADDR_W];
  logic [7:0] rdByte_r;
  logic fetchReq_r;
  logic writeEnableLatch_r;
  logic writeCmd_r;
  logic [5:0] statNv_r;
  logic pushValid_r;
  logic [WW-1:0] pushData_r;
  logic so_r;
  logic soEn_r;
  logic bufReady_r;
  logic csLow;
  logic sckNow;
  logic siNow;
  logic holdOn;
  logic guardLow;
  logic sckRise;
  logic sckFall;
  logic csRise;
  logic byteDone;
  logic [7:0] rxByte;
  logic [7:0] statusByte;
  logic fifoInReady;
  logic fifoOutValid;
  logic [WW-1:0] fifoOutData;
  logic drainReady;

  // opcode to first phase; unknown codes are swallowed
  function automatic spi_mem_pkg::cmd_state_type decodeOp(input logic [7:0] op);
    case (op)
      `OP_STATUS_READ: decodeOp = spi_mem_pkg::ST_STREAD;
      `OP_STATUS_WRITE: decodeOp = spi_mem_pkg::ST_STWRITE;
      `OP_ARRAY_READ, `OP_ARRAY_WRITE, `OP_FAST_READ: decodeOp = spi_mem_pkg::ST_ADDR;
      `OP_IDENTITY_READ: decodeOp = spi_mem_pkg::ST_IDOUT;
      default: decodeOp = spi_mem_pkg::ST_IGNORE;
    endcase
  endfunction

  // guarded upper part of the array selected by the two guard bits
  function automatic logic isGuarded(input logic [ADDR_W-1:0] a, input logic [1:0] bg);
    case (bg)
      2'h1: isGuarded = a[ADDR_W-1] && a[ADDR_W-2];
      2'h2: isGuarded = a[ADDR_W-1];
      2'h3: isGuarded = 1'b1;
      default: isGuarded = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers and edge finding
  // ------------------------------------------------------------------
  // order: chip select, clock, data in, hold, write-guard pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_r <= 5'h1b;
      sync2_r <= 5'h1b;
      sckPrev_r <= 1'b1;
      csLowPrev_r <= 1'b0;
    end else begin
      sync1_r <= {csN, sck, si, holdN, guardPinN};
      sync2_r <= sync1_r;
      sckPrev_r <= sync2_r[3];
      csLowPrev_r <= !sync2_r[4];
    end
  end

  assign csLow = !sync2_r[4];
  assign sckNow = sync2_r[3];
  assign siNow = sync2_r[2];
  assign holdOn = csLow && !sync2_r[1];
  assign guardLow = !sync2_r[0];
  // edges seen during hold are dropped, so the command just pauses
  assign sckRise = csLow && !holdOn && sckNow && !sckPrev_r;
  assign sckFall = csLow && !holdOn && !sckNow && sckPrev_r;
  assign csRise = !csLow && csLowPrev_r;
  assign byteDone = bitCnt_r == `LAST_BYTE_BIT;
  assign rxByte = {sh_r[6:0], siNow};
  assign statusByte = {statNv_r, writeEnableLatch_r, 1'b0};

  // ------------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------------
  // any deselect returns to op-code collection, discarding partial bits
  always_ff @(posedge mclk) begin
    if (srst || !csLow) begin
      state_r <= spi_mem_pkg::ST_OPCODE;
      access_r <= spi_mem_pkg::ACC_READ;
      bitCnt_r <= '0;
      sh_r <= '0;
    end else if (sckRise) begin
      sh_r <= rxByte;
      bitCnt_r <= bitCnt_r + 6'h01;
      unique case (state_r)
        spi_mem_pkg::ST_OPCODE: begin
          if (byteDone) begin
            bitCnt_r <= '0;
            state_r <= decodeOp(rxByte);
            if (rxByte == `OP_FAST_READ) access_r <= spi_mem_pkg::ACC_FAST;
            else if (rxByte == `OP_ARRAY_WRITE) access_r <= spi_mem_pkg::ACC_WRITE;
            else access_r <= spi_mem_pkg::ACC_READ;
          end
        end
        spi_mem_pkg::ST_ADDR: begin
          if (bitCnt_r == `LAST_ADDR_BIT) begin
            bitCnt_r <= '0;
            unique case (access_r)
              spi_mem_pkg::ACC_FAST: state_r <= spi_mem_pkg::ST_DUMMY;
              spi_mem_pkg::ACC_WRITE: state_r <= spi_mem_pkg::ST_WDATA;
              default: state_r <= spi_mem_pkg::ST_RDATA;
            endcase
          end
        end
        spi_mem_pkg::ST_DUMMY: begin
          if (byteDone) begin
            bitCnt_r <= '0;
            state_r <= spi_mem_pkg::ST_RDATA;
          end
        end
        spi_mem_pkg::ST_RDATA, spi_mem_pkg::ST_WDATA, spi_mem_pkg::ST_STREAD: begin
          if (byteDone) bitCnt_r <= '0;
        end
        spi_mem_pkg::ST_STWRITE: begin
          if (byteDone) state_r <= spi_mem_pkg::ST_IGNORE;
        end
        spi_mem_pkg::ST_IDOUT: begin
          if (bitCnt_r == `ID_BIT_COUNT) bitCnt_r <= bitCnt_r;
        end
        spi_mem_pkg::ST_IGNORE: bitCnt_r <= bitCnt_r;
        default: state_r <= spi_mem_pkg::ST_IGNORE;
      endcase
    end
  end

  // address shifts in whole; width drops the top bit, increment wraps to zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_r <= '0;
    end else if (sckRise && state_r == spi_mem_pkg::ST_ADDR) begin
      addr_r <= {addr_r[ADDR_W-2:0], siNow};
    end else if (sckRise && byteDone &&
                 (state_r == spi_mem_pkg::ST_RDATA || state_r == spi_mem_pkg::ST_WDATA)) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // write-enable latch and status bits
  // ------------------------------------------------------------------
  // cleared at the deselect that ends a recognised write; an abort before
  // recognition leaves it alone
  always_ff @(posedge mclk) begin
    if (srst) begin
      writeEnableLatch_r <= 1'b0;
      writeCmd_r <= 1'b0;
    end else begin
      if (!csLow) writeCmd_r <= 1'b0;
      if (csRise && writeCmd_r) begin
        writeEnableLatch_r <= 1'b0;
      end else if (sckRise && state_r == spi_mem_pkg::ST_OPCODE && byteDone) begin
        if (rxByte == `OP_WRITE_ENABLE) writeEnableLatch_r <= 1'b1;
        if (rxByte == `OP_WRITE_DISABLE) writeEnableLatch_r <= 1'b0;
        if (rxByte == `OP_STATUS_WRITE || rxByte == `OP_ARRAY_WRITE) writeCmd_r <= 1'b1;
      end
    end
  end

  // only bits 7..2 are stored; latch and zero positions are dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      statNv_r <= `STATUS_NV_RESET;
    end else if (sckRise && state_r == spi_mem_pkg::ST_STWRITE && byteDone &&
                 writeEnableLatch_r && !(statNv_r[5] && guardLow)) begin
      statNv_r <= rxByte[7:2];
    end
  end

  // ------------------------------------------------------------------
  // array access: reads fetch into a holding byte, writes queue
  // ------------------------------------------------------------------
  // fetch one cycle after the address or byte boundary settles
  always_ff @(posedge mclk) begin
    if (srst) begin
      fetchReq_r <= 1'b0;
      rdByte_r <= '0;
    end else begin
      fetchReq_r <= sckRise && ((state_r == spi_mem_pkg::ST_ADDR &&
                    bitCnt_r == `LAST_ADDR_BIT && access_r == spi_mem_pkg::ACC_READ) ||
                    (state_r == spi_mem_pkg::ST_DUMMY && byteDone) ||
                    (state_r == spi_mem_pkg::ST_RDATA && byteDone));
      if (fetchReq_r) rdByte_r <= mem_r[addr_r];
    end
  end

  // a byte is committed only after its 8th bit, and only if allowed
  always_ff @(posedge mclk) begin
    if (srst) begin
      pushValid_r <= 1'b0;
      pushData_r <= '0;
    end else begin
      pushValid_r <= sckRise && state_r == spi_mem_pkg::ST_WDATA && byteDone &&
                     writeEnableLatch_r && !isGuarded(addr_r, statNv_r[1:0]);
      pushData_r <= {addr_r, rxByte};
    end
  end

  // the array port serves the read fetch first, so the buffer drain stalls
  assign drainReady = !fetchReq_r;

  spi_mem_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) wrBuf (
    .mclk(mclk),
    .srst(srst),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .inData(pushData_r),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .outData(fifoOutData)
  );

  // array storage in flops, written from the buffer head
  always_ff @(posedge mclk) begin
    if (fifoOutValid && drainReady) mem_r[fifoOutData[WW-1:8]] <= fifoOutData[7:0];
  end

  // ------------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------------
  // bits change only on falling edges; identifier stops after its last bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      so_r <= 1'b0;
      soEn_r <= 1'b0;
      bufReady_r <= 1'b0;
    end else begin
      bufReady_r <= fifoInReady;
      soEn_r <= csLow && !holdOn && (state_r == spi_mem_pkg::ST_STREAD ||
                state_r == spi_mem_pkg::ST_RDATA || state_r == spi_mem_pkg::ST_IDOUT);
      if (sckFall) begin
        if (state_r == spi_mem_pkg::ST_STREAD) begin
          so_r <= statusByte[3'h7 - bitCnt_r[2:0]];
        end else if (state_r == spi_mem_pkg::ST_RDATA) begin
          so_r <= rdByte_r[3'h7 - bitCnt_r[2:0]];
        end else if (state_r == spi_mem_pkg::ST_IDOUT && bitCnt_r != `ID_BIT_COUNT) begin
          so_r <= ID_WORD[5'h1f - bitCnt_r[4:0]];
        end
      end
    end
  end

  assign so = so_r;
  assign soEn = soEn_r;
  assign bufReady = bufReady_r;
endmodule

// *** bench/spi_mem_slave_props.sv ***
// checker for the serial memory command slave, pins only
// assumes mclk 8x the serial clock or more and sck idling low
`timescale 1ns/1ps

module spi_mem_slave_props (
  input wire logic mclk,
  input wire logic srst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic holdN,
  input wire logic guardPinN,
  input wire logic so,
  input wire logic soEn,
  input wire logic bufReady
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ----------
  // sequences
  // ----------
  // pins must outlast the two-flop sync before the slave may react
  sequence deselected;
    csN [*6];
  endsequence
  sequence held;
    (!csN && !holdN) [*4];
  endsequence

  // ----------
  // properties
  // ----------
  a_rst_outputs: assert property ($fell(srst) |-> !soEn && !so && !bufReady)
    else $error("outputs not idle after reset");
  a_buf_after_rst: assert property ($fell(srst) |-> ##[1:3] bufReady)
    else $error("buffer not ready after reset");
  a_idle_float: assert property (deselected |-> !soEn)
    else $error("so driven while deselected");
  a_en_needs_sel: assert property ($rose(soEn) |-> !$past(csN, 2) && $past(holdN, 2))
    else $error("so enabled without select");
  a_hold_float: assert property (held |-> !soEn)
    else $error("so driven in hold");
  a_hold_frozen: assert property (held |-> $stable(so))
    else $error("so moved in hold");
  a_so_on_fall: assert property ($changed(so) && $past(soEn) |-> !$past(sck, 2))
    else $error("so changed away from a falling edge");
  a_so_high_stable: assert property (sck [*3] |-> $stable(so))
    else $error("so changed while sck high");
endmodule

bind spi_mem_slave spi_mem_slave_props i_spi_mem_slave_props (
  .mclk(mclk), .srst(srst), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
  .guardPinN(guardPinN), .so(so), .soEn(soEn), .bufReady(bufReady)
);

// *** bench/spi_host_model.sv ***
// host side model driving select, serial clock, data in and hold
// assumes its tasks are entered just after a falling mclk edge
`timescale 1ns/1ps

module spi_host_model (
  input wire logic mclk,
  input wire logic so,
  input wire logic soEn,
  output logic csN,
  output logic sck,
  output logic si,
  output logic holdN
);
  // ----------
  // pin drivers
  // ----------
  // deselected at time zero, sck idles low (mode 0)
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
  end

  task automatic waitn(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // 4 low + 4 high mclk: 320 ns, well under either clock limit
  task automatic bitx(input logic b, output logic r);
    sck = 1'b0;
    si = b;
    waitn(4);
    r = soEn ? so : ~so; // floating line reads as garbage, not as the last bit
    sck = 1'b1;
    waitn(4);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
  endtask

  task automatic start;
    csN = 1'b0;
    waitn(4);
  endtask

  // si flips after release so no stale level lingers on it
  task automatic stop;
    sck = 1'b0;
    waitn(4);
    csN = 1'b1;
    si = ~si;
    waitn(8);
  endtask

  task automatic hold(input logic h);
    holdN = h;
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the serial memory command slave
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps

module tb;
  localparam logic [31:0] ID_VAL = 32'h3c96a50f; // arbitrary identifier value
  localparam logic [15:0] BASE [4] = '{16'h8000, 16'h6000, 16'h4000, 16'h0000};
  logic mclk;
  logic srst;
  logic guardPinN;
  logic csN, sck, si, holdN, so, soEn, bufReady;
  int n_errors = 0;
  int check_count = 0;
  logic [7:0] rx;

  // ----------
  // clock, design, host
  // ----------
  always #20 mclk = ~mclk;

  spi_mem_slave #(.ID_WORD(ID_VAL)) i_spi_mem_slave (
    .mclk(mclk), .srst(srst), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
    .guardPinN(guardPinN), .so(so), .soEn(soEn), .bufReady(bufReady)
  );
  spi_host_model i_spi_host_model (
    .mclk(mclk), .so(so), .soEn(soEn), .csN(csN), .sck(sck), .si(si), .holdN(holdN)
  );

  // ----------
  // checks and frames
  // ----------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic head(input logic [7:0] c);
    i_spi_host_model.start();
    i_spi_host_model.xfer(c, rx);
  endtask

  task automatic op(input logic [7:0] c);
    head(c);
    i_spi_host_model.stop();
  endtask

  // two bytes in one frame: the status byte must repeat
  task automatic st_exp(input logic [7:0] e);
    head(8'h05);
    repeat (2) begin
      i_spi_host_model.xfer(8'hc3, rx);
      chk8(rx, e);
    end
    i_spi_host_model.stop();
  endtask

  // guard pin is only moved between frames
  task automatic sw(input logic [7:0] v);
    op(8'h06);
    head(8'h01);
    i_spi_host_model.xfer(v, rx);
    i_spi_host_model.stop();
  endtask

  task automatic wr(input logic en, input logic [15:0] a, input logic [7:0] d0, d1);
    if (en) op(8'h06);
    head(8'h02);
    i_spi_host_model.xfer(a[15:8], rx);
    i_spi_host_model.xfer(a[7:0], rx);
    i_spi_host_model.xfer(d0, rx);
    i_spi_host_model.xfer(d1, rx);
    i_spi_host_model.stop();
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] e0, e1);
    head(c);
    i_spi_host_model.xfer(a[15:8], rx);
    i_spi_host_model.xfer(a[7:0], rx);
    if (c == 8'h0b) i_spi_host_model.xfer(8'h5a, rx);
    i_spi_host_model.xfer(8'hff, rx);
    chk8(rx, e0);
    i_spi_host_model.xfer(8'hff, rx);
    chk8(rx, e1);
    i_spi_host_model.stop();
  endtask

  // all but the last bit of write-disable, optionally cut off by deselect during hold
  task automatic part(input logic h);
    logic r;
    logic [7:0] c = 8'h04;
    i_spi_host_model.start();
    for (int i = 7; i > 0; i--) i_spi_host_model.bitx(c[i], r);
    i_spi_host_model.hold(~h);
    i_spi_host_model.waitn(4);
    i_spi_host_model.stop();
    i_spi_host_model.hold(1'b1);
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_latch;
    st_exp(8'h00);
    op(8'h06);
    st_exp(8'h02);
    op(8'h04);
    st_exp(8'h00);
  endtask

  task automatic t_array;
    wr(1'b1, 16'h8010, 8'ha1, 8'h5c);
    st_exp(8'h00);
    rd(8'h03, 16'h0010, 8'ha1, 8'h5c);
    wr(1'b0, 16'h0010, 8'h11, 8'h22);
    rd(8'h0b, 16'h8010, 8'ha1, 8'h5c);
    wr(1'b1, 16'h7fff, 8'h3c, 8'hc3);
    rd(8'h03, 16'h7fff, 8'h3c, 8'hc3);
    rd(8'h0b, 16'hffff, 8'h3c, 8'hc3);
  endtask

  // every guard code: write across its lower boundary, then read back
  task automatic t_guard;
    logic [7:0] g;
    for (int k = 0; k < 4; k++) begin
      g = 8'(k);
      sw(8'h00);
      wr(1'b1, BASE[k] - 16'h0001, 8'h10 + g, 8'h20 + g);
      sw((g << 2) | 8'h03);
      st_exp(g << 2);
      wr(1'b1, BASE[k] - 16'h0001, 8'h30 + g, 8'h40 + g);
      sw(8'h00);
      rd(8'h03, BASE[k] - 16'h0001, (k == 3) ? 8'h10 + g : 8'h30 + g,
         (k == 0) ? 8'h40 + g : 8'h20 + g);
    end
    sw(8'h80);
    guardPinN = 1'b0;
    sw(8'h0c);
    st_exp(8'h80);
    guardPinN = 1'b1;
    sw(8'h00);
    st_exp(8'h00);
  endtask

  task automatic t_hold;
    logic r;
    logic [7:0] v;
    op(8'h06);
    head(8'h05);
    for (int i = 7; i >= 0; i--) begin
      if (i == 3) begin
        i_spi_host_model.hold(1'b0);
        i_spi_host_model.waitn(6);
        chk1(soEn, 1'b0);
        i_spi_host_model.bitx(1'b1, r);
        i_spi_host_model.hold(1'b1);
        i_spi_host_model.waitn(4);
      end
      i_spi_host_model.bitx(1'b0, v[i]);
    end
    chk8(v, 8'h02);
    i_spi_host_model.stop();
    part(1'b1);
    st_exp(8'h02);
    part(1'b0);
    st_exp(8'h02);
    op(8'h04);
  endtask

  task automatic t_id;
    head(8'h9f);
    for (int k = 3; k >= 0; k--) begin
      i_spi_host_model.xfer(8'hff, rx);
      chk8(rx, ID_VAL[8*k +: 8]);
    end
    i_spi_host_model.xfer(8'h00, rx);
    chk8(rx, {8{ID_VAL[0]}});
    i_spi_host_model.stop();
  endtask

  // ----------
  // run control
  // ----------
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence after five reset cycles
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    guardPinN = 1'b1;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    i_spi_host_model.waitn(4);
    t_latch();
    t_array();
    t_guard();
    t_hold();
    t_id();
    close_out();
  end

  // run needs about 14k cycles; over four times that means a hang
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    close_out();
  end
endmodule
